// ### logic/synth_cfg_pkg.sv
// register map, field layout and reset values of the synthesizer output configuration
package synth_cfg_pkg;

  // register offsets in the eight-bit space
  localparam logic [7:0] OFS_FILTER = 8'h77;
  localparam logic [7:0] OFS_PHASE0 = 8'h78;
  localparam logic [7:0] OFS_PHASE1 = 8'h79;
  localparam logic [7:0] OFS_BANK = 8'h7F;
  localparam logic [7:0] OFS_DIV_A = 8'h80;
  localparam logic [7:0] OFS_DIV_B = 8'h83;
  localparam logic [7:0] OFS_DIV_C = 8'h86;
  localparam logic [6:0] BANK_ADDR7 = 7'h7F;
  localparam logic [7:0] DIV_BYTES = 8'h03;

  // reset values
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [23:0] RST_DIV_A = 24'h00_0002;
  localparam logic [23:0] RST_DIV_B = 24'h00_0002;
  localparam logic [23:0] RST_DIV_C = 24'h00_0040;

  // field positions
  localparam int FILTER0_BIT = 0;
  localparam int FILTER1_BIT = 1;
  localparam int BANK_BIT = 0;
  localparam int AB_RATIO_MSB = 22;
  localparam int C_MODE_LSB = 20;
  localparam int C_TYPE_BIT = 19;
  localparam int C_POL_BIT = 18;
  localparam int C_SEL_LSB = 16;
  localparam int C_PERIOD_MSB = 15;
  localparam logic [3:0] FRAME_MODE_CODE = 4'hF;

  // related clock choice for the frame pulse
  localparam logic [1:0] REL_DIV_A = 2'h0;
  localparam logic [1:0] REL_DIV_B = 2'h1;
  localparam logic [1:0] REL_RESERVED = 2'h2;
  localparam logic [1:0] REL_DIV_D = 2'h3;

  typedef struct packed {
    logic [7:0] filter;
    logic [7:0] phase0;
    logic [7:0] phase1;
    logic [7:0] bank;
    logic [23:0] div_a;
    logic [23:0] div_b;
    logic [23:0] div_c;
  } cfg_s;

  typedef struct packed {
    logic [15:0] period;
    logic [1:0] sel;
    logic invert;
    logic edge_type;
  } frame_cfg_s;

endpackage

// ### logic/ratio_divider.sv
// integer divider, 50% duty at even ratios, producing a clock level and a period-start tick
`timescale 1ns/1ps
module ratio_divider #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  input wire logic [WIDTH-1:0] ratio_i,
  // divided clock
  output logic level_o,
  output logic tick_o
);

  if (WIDTH < 2) begin : g_chk
    $error("ratio_divider needs WIDTH of at least 2");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic level;
    logic tick;
  } div_state_s;

  div_state_s st_r;
  div_state_s st_nxt;
  logic [WIDTH-1:0] n_eff;
  logic [WIDTH-1:0] hi_cnt;

  // ratios below two run as two
  assign n_eff = (ratio_i < WIDTH'(2)) ? WIDTH'(2) : ratio_i;
  // high phase is the larger half for odd ratios
  assign hi_cnt = WIDTH'((n_eff + WIDTH'(1)) >> 1);

  always_comb
  begin
    st_nxt = st_r;
    if (!en_i)
    begin
      st_nxt = '0;
    end
    else
    begin
      st_nxt.cnt = (st_r.cnt >= n_eff - WIDTH'(1)) ? '0 : st_r.cnt + WIDTH'(1);
      st_nxt.tick = (st_nxt.cnt == '0);
      st_nxt.level = (st_nxt.cnt < hi_cnt);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level_o = st_r.level;
  assign tick_o = st_r.tick;

  // helper: cycles spent high, and whether the phase began at a clean tick
  logic [WIDTH-1:0] hi_seen_r;
  logic [WIDTH-1:0] ratio_q_r;
  logic phase_ok_r;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hi_seen_r <= '0;
      ratio_q_r <= '0;
      phase_ok_r <= 1'b0;
    end
    else
    begin
      ratio_q_r <= ratio_i;
      if (st_r.level)
        hi_seen_r <= hi_seen_r + WIDTH'(1);
      else
        hi_seen_r <= '0;
      // a phase cut by reset, enable or a ratio change is not measured
      if (!en_i || ratio_i != ratio_q_r)
        phase_ok_r <= 1'b0;
      else if (st_r.tick)
        phase_ok_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tick_spacing: assert property (st_r.tick && en_i && $stable(ratio_i)
      |=> !st_r.tick && (st_r.cnt == WIDTH'(1)))
    else $error("divider tick not followed by count one");
  a_high_half: assert property ($fell(st_r.level) && en_i && $stable(ratio_i)
      && $past(en_i) && phase_ok_r |-> hi_seen_r == hi_cnt)
    else $error("divider high phase length wrong");

endmodule

// ### logic/frame_pulse_gen.sv
// frame pulse generator counting periods of a chosen related clock
`timescale 1ns/1ps
module frame_pulse_gen #(
  parameter int PERIOD_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  input wire synth_cfg_pkg::frame_cfg_s cfg_i,
  // related clocks, index is the select code
  input wire logic [3:0] rel_level_i,
  input wire logic [3:0] rel_tick_i,
  // pulse
  output logic pulse_o
);

  if (PERIOD_W != 16) begin : g_chk
    $error("frame_pulse_gen period field is 16 bits");
  end

  typedef struct packed {
    logic [PERIOD_W-1:0] cnt;
    logic pulse;
  } frm_state_s;

  frm_state_s st_r;
  frm_state_s st_nxt;
  logic sel_ok;
  logic lvl;
  logic tck;
  logic [PERIOD_W-1:0] last;
  logic active;

  always_comb
  begin
    sel_ok = (cfg_i.sel != synth_cfg_pkg::REL_RESERVED);
    lvl = rel_level_i[cfg_i.sel];
    tck = rel_tick_i[cfg_i.sel];
    last = (cfg_i.period == '0) ? '0 : cfg_i.period - PERIOD_W'(1);
    st_nxt = st_r;
    active = 1'b0;
    if (!en_i || !sel_ok)
    begin
      st_nxt.cnt = '0;
    end
    else if (tck)
    begin
      st_nxt.cnt = (st_r.cnt >= last) ? '0 : st_r.cnt + PERIOD_W'(1);
    end
    if (en_i && sel_ok)
    begin
      if (cfg_i.edge_type)
        active = (st_nxt.cnt == '0);
      else
        active = (st_nxt.cnt == '0 && lvl) || (st_nxt.cnt == last && !lvl);
    end
    st_nxt.pulse = active ^ cfg_i.invert;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign pulse_o = st_r.pulse;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reserved_idle: assert property (en_i && cfg_i.sel == synth_cfg_pkg::REL_RESERVED
      |=> pulse_o == $past(cfg_i.invert))
    else $error("reserved related clock made a pulse");
  a_edge_start: assert property (en_i && sel_ok && cfg_i.edge_type && tck
      && st_r.cnt >= last && $stable(cfg_i) |=> pulse_o == !$past(cfg_i.invert))
    else $error("edge type pulse missing at boundary");
  a_off_boundary: assert property (en_i && sel_ok && st_nxt.cnt != '0
      && st_nxt.cnt != last |=> pulse_o == $past(cfg_i.invert))
    else $error("frame pulse active away from boundary");

endmodule

// ### logic/synth_output_divider_config.sv
// configuration registers and synthesizer 0 post dividers for two synthesizers
// Behaviour
// - filter choice bit 0 picks external (0) or internal (1) filter, synth 0.
// - filter choice bit 1 picks external (0) or internal (1) filter, synth 1.
// - 8-bit phase advance for all synth 0 clocks, steps of period/256.
// - independent 8-bit phase advance for all synth 1 clocks, period/256 steps.
// - bank bit 0 selects lower locations 0x00-0x7E or upper from 0x80.
// - seven-bit address; host sets bank before touching upper registers.
// - divider A bits 22:0 divide synth 0; software keeps bit 23 zero.
// - divider B bits 22:0 divide synth 0; software keeps bit 23 zero.
// - divider C top nibble all ones: frame pulse, bits 15:0 count periods.
// - otherwise whole 24-bit divider C divides VCO with nominal 50% duty.
// - duty 45-55% for even and odd ratios of 41 up; small odd higher.
// - bits 17:16 pick related clock A, B or D; code 10 reserved.
// - bit 18 inverts pulse; bit 19 picks middle (0) or edge (1) boundary.
`timescale 1ns/1ps
module synth_output_divider_config (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // serial port register side
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [6:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // divider D from outside this block
  input wire logic DIV_D_LEVEL_I,
  input wire logic DIV_D_TICK_I,
  // synthesizer controls
  output logic [1:0] FILTER_INTERNAL_O,
  output logic [7:0] PHASE_ADV0_O,
  output logic [7:0] PHASE_ADV1_O,
  // synthesizer 0 post divider outputs
  output logic DIV_A_CLK_O,
  output logic DIV_B_CLK_O,
  output logic DIV_C_O,
  output logic FRAME_MODE_O
);

  // ==========================================================
  // state
  typedef struct packed {
    synth_cfg_pkg::cfg_s cfg;
    logic [7:0] rdata;
    logic rvalid;
    logic div_c_out;
    logic frame_mode;
  } top_state_s;

  top_state_s st_r;
  top_state_s st_nxt;

  logic [7:0] full_addr;
  logic [7:0] off_a;
  logic [7:0] off_b;
  logic [7:0] off_c;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic frame_mode;
  logic a_level;
  logic a_tick;
  logic b_level;
  logic b_tick;
  logic c_level;
  logic frm_pulse;
  logic [23:0] ratio_a;
  logic [23:0] ratio_b;
  synth_cfg_pkg::frame_cfg_s frm_cfg;

  function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [1:0] k);
    logic [7:0] b;
    case (k)
      2'h0: b = v[23:16];
      2'h1: b = v[15:8];
      default: b = v[7:0];
    endcase
    return b;
  endfunction

  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] k,
                                           input logic [7:0] d);
    logic [23:0] r;
    r = v;
    case (k)
      2'h0: r[23:16] = d;
      2'h1: r[15:8] = d;
      default: r[7:0] = d;
    endcase
    return r;
  endfunction

  // ==========================================================
  // address paging
  always_comb
  begin
    if (REG_ADDR_I == synth_cfg_pkg::BANK_ADDR7)
      full_addr = synth_cfg_pkg::OFS_BANK;
    else
      full_addr = {st_r.cfg.bank[synth_cfg_pkg::BANK_BIT], REG_ADDR_I};
    off_a = full_addr - synth_cfg_pkg::OFS_DIV_A;
    off_b = full_addr - synth_cfg_pkg::OFS_DIV_B;
    off_c = full_addr - synth_cfg_pkg::OFS_DIV_C;
    hit_a = (full_addr >= synth_cfg_pkg::OFS_DIV_A) && (off_a < synth_cfg_pkg::DIV_BYTES);
    hit_b = (full_addr >= synth_cfg_pkg::OFS_DIV_B) && (off_b < synth_cfg_pkg::DIV_BYTES);
    hit_c = (full_addr >= synth_cfg_pkg::OFS_DIV_C) && (off_c < synth_cfg_pkg::DIV_BYTES);
  end

  // ==========================================================
  // register file
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (REG_WR_I)
    begin
      // whole bytes stored, reserved bits included
      case (full_addr)
        synth_cfg_pkg::OFS_FILTER: st_nxt.cfg.filter = REG_WDATA_I;
        synth_cfg_pkg::OFS_PHASE0: st_nxt.cfg.phase0 = REG_WDATA_I;
        synth_cfg_pkg::OFS_PHASE1: st_nxt.cfg.phase1 = REG_WDATA_I;
        synth_cfg_pkg::OFS_BANK: st_nxt.cfg.bank = REG_WDATA_I;
        default:
        begin
          if (hit_a)
            st_nxt.cfg.div_a = put_byte(st_r.cfg.div_a, off_a[1:0], REG_WDATA_I);
          if (hit_b)
            st_nxt.cfg.div_b = put_byte(st_r.cfg.div_b, off_b[1:0], REG_WDATA_I);
          if (hit_c)
            st_nxt.cfg.div_c = put_byte(st_r.cfg.div_c, off_c[1:0], REG_WDATA_I);
        end
      endcase
    end
    else if (REG_RD_I)
    begin
      st_nxt.rvalid = 1'b1;
      case (full_addr)
        synth_cfg_pkg::OFS_FILTER: st_nxt.rdata = st_r.cfg.filter;
        synth_cfg_pkg::OFS_PHASE0: st_nxt.rdata = st_r.cfg.phase0;
        synth_cfg_pkg::OFS_PHASE1: st_nxt.rdata = st_r.cfg.phase1;
        synth_cfg_pkg::OFS_BANK: st_nxt.rdata = st_r.cfg.bank;
        default:
        begin
          if (hit_a)
            st_nxt.rdata = get_byte(st_r.cfg.div_a, off_a[1:0]);
          else if (hit_b)
            st_nxt.rdata = get_byte(st_r.cfg.div_b, off_b[1:0]);
          else if (hit_c)
            st_nxt.rdata = get_byte(st_r.cfg.div_c, off_c[1:0]);
          else
            st_nxt.rdata = 8'h00;
        end
      endcase
    end
    st_nxt.frame_mode = frame_mode;
    st_nxt.div_c_out = frame_mode ? frm_pulse : c_level;
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      st_r <= '0;
      st_r.cfg.filter <= synth_cfg_pkg::RST_FILTER;
      st_r.cfg.phase0 <= synth_cfg_pkg::RST_PHASE;
      st_r.cfg.phase1 <= synth_cfg_pkg::RST_PHASE;
      st_r.cfg.bank <= synth_cfg_pkg::RST_BANK;
      st_r.cfg.div_a <= synth_cfg_pkg::RST_DIV_A;
      st_r.cfg.div_b <= synth_cfg_pkg::RST_DIV_B;
      st_r.cfg.div_c <= synth_cfg_pkg::RST_DIV_C;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // post dividers
  // bit 23 of A and B is not part of the ratio
  assign ratio_a = {1'b0, st_r.cfg.div_a[synth_cfg_pkg::AB_RATIO_MSB:0]};
  assign ratio_b = {1'b0, st_r.cfg.div_b[synth_cfg_pkg::AB_RATIO_MSB:0]};
  assign frame_mode = (st_r.cfg.div_c[23:synth_cfg_pkg::C_MODE_LSB]
                       == synth_cfg_pkg::FRAME_MODE_CODE);
  assign frm_cfg.period = st_r.cfg.div_c[synth_cfg_pkg::C_PERIOD_MSB:0];
  assign frm_cfg.sel = st_r.cfg.div_c[synth_cfg_pkg::C_SEL_LSB+1:synth_cfg_pkg::C_SEL_LSB];
  assign frm_cfg.invert = st_r.cfg.div_c[synth_cfg_pkg::C_POL_BIT];
  assign frm_cfg.edge_type = st_r.cfg.div_c[synth_cfg_pkg::C_TYPE_BIT];

  ratio_divider #(.WIDTH(24)) u_div_a (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .en_i(1'b1),
    .ratio_i(ratio_a),
    .level_o(a_level),
    .tick_o(a_tick)
  );

  ratio_divider #(.WIDTH(24)) u_div_b (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .en_i(1'b1),
    .ratio_i(ratio_b),
    .level_o(b_level),
    .tick_o(b_tick)
  );

  ratio_divider #(.WIDTH(24)) u_div_c (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .en_i(!frame_mode),
    .ratio_i(st_r.cfg.div_c),
    .level_o(c_level),
    .tick_o()
  );

  // index 2 is divider C itself and is never a source
  frame_pulse_gen #(.PERIOD_W(16)) u_frame (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .en_i(frame_mode),
    .cfg_i(frm_cfg),
    .rel_level_i({DIV_D_LEVEL_I, 1'b0, b_level, a_level}),
    .rel_tick_i({DIV_D_TICK_I, 1'b0, b_tick, a_tick}),
    .pulse_o(frm_pulse)
  );

  // ==========================================================
  // outputs
  assign REG_RDATA_O = st_r.rdata;
  assign REG_RVALID_O = st_r.rvalid;
  assign FILTER_INTERNAL_O = {st_r.cfg.filter[synth_cfg_pkg::FILTER1_BIT],
                              st_r.cfg.filter[synth_cfg_pkg::FILTER0_BIT]};
  assign PHASE_ADV0_O = st_r.cfg.phase0;
  assign PHASE_ADV1_O = st_r.cfg.phase1;
  assign DIV_A_CLK_O = a_level;
  assign DIV_B_CLK_O = b_level;
  assign DIV_C_O = st_r.div_c_out;
  assign FRAME_MODE_O = st_r.frame_mode;

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_write_at(logic [7:0] a);
    REG_WR_I && full_addr == a;
  endsequence

  sequence s_read_upper_zero;
    REG_RD_I && !REG_WR_I && st_r.cfg.bank[0] && REG_ADDR_I == 7'h00;
  endsequence

  a_filter_zero: assert property (s_write_at(synth_cfg_pkg::OFS_FILTER)
      |=> FILTER_INTERNAL_O[0] == $past(REG_WDATA_I[0]))
    else $error("synth 0 filter choice not applied");
  a_filter_one: assert property (s_write_at(synth_cfg_pkg::OFS_FILTER)
      |=> FILTER_INTERNAL_O[1] == $past(REG_WDATA_I[1]))
    else $error("synth 1 filter choice not applied");
  a_phase_zero: assert property (s_write_at(synth_cfg_pkg::OFS_PHASE0)
      |=> PHASE_ADV0_O == $past(REG_WDATA_I) && $stable(PHASE_ADV1_O))
    else $error("synth 0 phase advance wrong");
  a_phase_one: assert property (s_write_at(synth_cfg_pkg::OFS_PHASE1)
      |=> PHASE_ADV1_O == $past(REG_WDATA_I) && $stable(PHASE_ADV0_O))
    else $error("synth 1 phase advance wrong");
  a_bank_upper: assert property (s_read_upper_zero
      |=> REG_RVALID_O && REG_RDATA_O == $past(st_r.cfg.div_a[23:16]))
    else $error("upper bank read wrong");
  a_bank_lower: assert property (REG_RD_I && !REG_WR_I && !st_r.cfg.bank[0]
      && REG_ADDR_I == 7'h78 |=> REG_RDATA_O == $past(st_r.cfg.phase0))
    else $error("lower bank read wrong");
  a_ratio_top_bit: assert property (s_write_at(synth_cfg_pkg::OFS_DIV_B)
      |=> st_r.cfg.div_b[23] == $past(REG_WDATA_I[7]) && ratio_b[23] == 1'b0)
    else $error("divider B top bit handling wrong");
  a_ratio_a_top: assert property (s_write_at(synth_cfg_pkg::OFS_DIV_A)
      |=> ratio_a == {1'b0, $past(REG_WDATA_I[6:0]), $past(st_r.cfg.div_a[15:0])})
    else $error("divider A ratio wrong");
  a_mode_route: assert property (frame_mode && $past(frame_mode)
      |=> DIV_C_O == $past(frm_pulse) && FRAME_MODE_O)
    else $error("divider C output source wrong");
  a_reserved_keep: assert property (s_write_at(synth_cfg_pkg::OFS_FILTER)
      |=> st_r.cfg.filter == $past(REG_WDATA_I))
    else $error("reserved filter bits not kept");
  a_bank_keep: assert property (s_write_at(synth_cfg_pkg::OFS_BANK)
      |=> st_r.cfg.bank == $past(REG_WDATA_I))
    else $error("bank register byte not kept");
  a_upper_no_alias: assert property (REG_RD_I && !REG_WR_I && st_r.cfg.bank[0]
      && REG_ADDR_I == 7'h77 |=> REG_RVALID_O && REG_RDATA_O == 8'h00)
    else $error("upper bank read reached a lower register");
  a_ratio_b_low: assert property (s_write_at(synth_cfg_pkg::OFS_DIV_B + 8'h02)
      |=> ratio_b[7:0] == $past(REG_WDATA_I))
    else $error("divider B low byte not applied");
  a_normal_route: assert property (!frame_mode
      |=> DIV_C_O == $past(c_level) && !FRAME_MODE_O)
    else $error("divider C clock not routed in normal mode");
  a_c_idle_frame: assert property (frame_mode
      |=> !c_level)
    else $error("divider C counter ran in frame mode");

endmodule

// ### sim/host_model.sv
// host processor model driving the seven-bit register port
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic wr_o,
  output logic rd_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  logic bank_r;
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
    bank_r = 1'b0;
  end
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  // bank register set before reaching the other half
  task automatic page(input logic [7:0] a);
    if (a != 8'h7F && a[7] !== bank_r)
    begin
      put(7'h7F, {7'h00, a[7]});
      bank_r = a[7];
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    page(a);
    put(a[6:0], d);
    if (a == 8'h7F)
      bank_r = d[0];
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    page(a);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a[6:0];
    @(negedge clk_i);
    rd_o = 1'b0;
    n = 0;
    while (rvalid_i !== 1'b1 && n < 8)
    begin
      @(negedge clk_i);
      n++;
    end
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
  // dividers are sent high byte first
  task automatic write_div(input logic [7:0] a, input logic [23:0] v);
    logic [23:0] w;
    w = v;
    if (a != 8'h86)
      w[23] = 1'b0;
    else if (w[23:20] != 4'hF && w > 24'hEF_FFFF)
      w = 24'hEF_FFFF;
    for (int i = 0; i < 3; i++)
      write_reg(a + 8'(i), w[23-8*i -: 8]);
  endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench for the synthesizer output configuration block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk;
  logic reset;
  logic reg_wr;
  logic reg_rd;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [2:0] d_cnt;
  logic [1:0] filt;
  logic [7:0] ph0;
  logic [7:0] ph1;
  logic div_a;
  logic div_b;
  logic div_c;
  logic frame_mode;
  logic [7:0] rb;
  logic [71:0] dflt;
  int failures;
  int tests_run;
  int hi;
  int lo;
  int rel;
  int ratios [3] = '{6, 7, 41};
  logic [23:0] frm [5] = '{24'hF8_0003, 24'hF0_0003, 24'hF4_0003, 24'hF9_0003, 24'hFB_0002};

  synth_output_divider_config dut (
    .SYS_CLK_I(sys_clk), .RESET_I(reset),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata), .REG_RVALID_O(reg_rvalid),
    .DIV_D_LEVEL_I(d_cnt < 3'h3), .DIV_D_TICK_I(d_cnt == 3'h0),
    .FILTER_INTERNAL_O(filt), .PHASE_ADV0_O(ph0), .PHASE_ADV1_O(ph1),
    .DIV_A_CLK_O(div_a), .DIV_B_CLK_O(div_b), .DIV_C_O(div_c),
    .FRAME_MODE_O(frame_mode)
  );
  host_model host (
    .clk_i(sys_clk), .wr_o(reg_wr), .rd_o(reg_rd), .addr_o(reg_addr),
    .wdata_o(reg_wdata), .rdata_i(reg_rdata), .rvalid_i(reg_rvalid)
  );

  initial
  begin
    sys_clk = 1'b0;
    reset = 1'b1;
    d_cnt = 3'h0;
    failures = 0;
    tests_run = 0;
  end
  always #4 sys_clk = ~sys_clk;
  // divider D stand-in, ratio 6
  always @(negedge sys_clk)
    d_cnt <= (reset || d_cnt == 3'h5) ? 3'h0 : d_cnt + 3'h1;

  task automatic end_sim();
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      failures++;
      $display("BAD %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? div_a : (s == 1) ? div_b : div_c;
  endfunction
  // high and low run lengths of one full period
  task automatic measure(input int s, output int h, output int l);
    int n;
    h = 0;
    l = 0;
    n = 0;
    while (pick(s) !== 1'b0 && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
    while (pick(s) !== 1'b1 && n < 600)
    begin
      @(negedge sys_clk);
      n++;
    end
    while (pick(s) === 1'b1 && h < 300)
    begin
      @(negedge sys_clk);
      h++;
    end
    while (pick(s) === 1'b0 && l < 300)
    begin
      @(negedge sys_clk);
      l++;
    end
  endtask

  // ==========================================
  // tests
  initial
  begin
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    dflt = {synth_cfg_pkg::RST_DIV_A, synth_cfg_pkg::RST_DIV_B, synth_cfg_pkg::RST_DIV_C};
    host.read_reg(8'h7F, rb);
    chk_byte(rb, synth_cfg_pkg::RST_BANK);
    for (int i = 0; i < 3; i++)
    begin
      host.read_reg(8'h77 + 8'(i), rb);
      chk_byte(rb, 8'h00);
    end
    for (int i = 0; i < 9; i++)
    begin
      host.read_reg(8'h80 + 8'(i), rb);
      chk_byte(rb, dflt[71-8*i -: 8]);
    end
    chk_byte({6'h00, filt}, 8'h00);
    chk_byte(ph0 | ph1, 8'h00);
    // filter choice with reserved bits kept
    for (int i = 0; i < 2; i++)
    begin
      host.write_reg(8'h77, i == 0 ? 8'hFE : 8'h01);
      repeat (2) @(negedge sys_clk);
      chk_byte({6'h00, filt}, i == 0 ? 8'h02 : 8'h01);
      host.read_reg(8'h77, rb);
      chk_byte(rb, i == 0 ? 8'hFE : 8'h01);
    end
    host.write_reg(8'h78, 8'hA5);
    host.write_reg(8'h79, 8'h5A);
    repeat (2) @(negedge sys_clk);
    chk_byte(ph0, 8'hA5);
    chk_byte(ph1, 8'h5A);
    // upper twin of 0x77 must not alias it
    host.write_reg(8'hF7, 8'h33);
    host.read_reg(8'hF7, rb);
    chk_byte(rb, 8'h00);
    host.read_reg(8'h77, rb);
    chk_byte(rb, 8'h01);
    host.read_reg(8'h7A, rb);
    chk_byte(rb, 8'h00);
    // dividers A and B
    host.write_div(8'h80, 24'h80_0004);
    host.write_div(8'h83, 24'h00_0005);
    host.read_reg(8'h80, rb);
    chk_byte(rb, 8'h00);
    measure(0, hi, lo);
    chk_cnt(hi, 2);
    chk_cnt(lo, 2);
    measure(1, hi, lo);
    chk_cnt(hi, 3);
    chk_cnt(lo, 2);
    // divider C normal clock, even and odd ratios
    for (int i = 0; i < 3; i++)
    begin
      host.write_div(8'h86, 24'(ratios[i]));
      repeat (2) @(negedge sys_clk);
      chk_byte({7'h00, frame_mode}, 8'h00);
      measure(2, hi, lo);
      measure(2, hi, lo);
      chk_cnt(hi, (ratios[i] + 1) / 2);
      chk_cnt(lo, ratios[i] / 2);
    end
    // frame pulse shapes, related clocks A 4, B 5, D 6
    for (int i = 0; i < 5; i++)
    begin
      host.write_div(8'h86, frm[i]);
      repeat (2) @(negedge sys_clk);
      chk_byte({7'h00, frame_mode}, 8'h01);
      rel = (frm[i][17:16] == 2'h0) ? 4 : (frm[i][17:16] == 2'h1) ? 5 : 6;
      measure(2, hi, lo);
      measure(2, hi, lo);
      chk_cnt(hi, frm[i][18] ? (int'(frm[i][15:0]) - 1) * rel : rel);
      chk_cnt(lo, frm[i][18] ? rel : (int'(frm[i][15:0]) - 1) * rel);
    end
    // reserved related clock holds the inactive level
    host.write_div(8'h86, 24'hF6_0003);
    repeat (4) @(negedge sys_clk);
    hi = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge sys_clk);
      hi += (div_c === 1'b1) ? 1 : 0;
    end
    chk_cnt(hi, 40);
    end_sim();
  end

  initial
  begin
    #200_000;
    failures++;
    end_sim();
  end
endmodule
